// ---- design/reading_fifo.sv ----
// Output buffer FIFO with valid and ready on both sides
`timescale 1ns/1ns
module reading_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Fill side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // Drain side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic      [WIDTH-1:0]           out_data,
    output logic      [$clog2(DEPTH):0]     level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Honest flags straight from the occupancy count
    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign level     = count_ff;

    // Storage written only on an accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers wrap with depth a power of two
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
            rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
            count_ff  <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : reading_fifo

// ---- design/reading_store.sv ----
// Reading sequencer with stored and direct transfer modes and AXI4-Lite registers
`timescale 1ns/1ns
`include "rs_defs.svh"
module reading_store #(
    parameter int LINE_CLKS = `RS_LINE_PERIOD_NS / `RS_CLK_PERIOD_NS,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // Measurement front end
    input  wire logic [15:0] SENSE_IN,
    input  wire logic        EXT_TRIG,
    // AXI4-Lite write channels
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read channels
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    // ****************************************
    // Register bus slave
    // ****************************************
    logic        aw_ff, w_ff, bvalid_ff, rvalid_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [3:0]  wstrb_ff;

    assign S_AXI_AWREADY = !aw_ff && !bvalid_ff;
    assign S_AXI_WREADY  = !w_ff && !bvalid_ff;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_BRESP   = bresp_ff;
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign S_AXI_RDATA   = rdata_ff;
    assign S_AXI_RRESP   = rresp_ff;

    wire do_write = aw_ff && w_ff && !bvalid_ff;
    wire do_read  = S_AXI_ARVALID && !rvalid_ff;
    wire wr_hit   = awaddr_ff[7:5] == 3'h0 && awaddr_ff[1:0] == 2'h0
                    && awaddr_ff != `RS_ADDR_STATUS && awaddr_ff != `RS_ADDR_DATA;
    wire rd_hit   = S_AXI_ARADDR[7:5] == 3'h0 && S_AXI_ARADDR[1:0] == 2'h0;
    wire wr_ctrl  = do_write && awaddr_ff == `RS_ADDR_CTRL && wstrb_ff[0];
    wire wr_cfg   = do_write && awaddr_ff == `RS_ADDR_CONFIG && wstrb_ff[0];
    wire wr_count = do_write && awaddr_ff == `RS_ADDR_COUNT;
    wire wr_aper  = do_write && awaddr_ff == `RS_ADDR_APER;
    wire wr_lcc   = do_write && awaddr_ff == `RS_ADDR_LCC && wstrb_ff[0];
    wire wr_res   = do_write && awaddr_ff == `RS_ADDR_RES && wstrb_ff[0];

    // Address and data latch in either order; response after both
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RS_RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_ff     <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;                         // Strobes mean nothing once WVALID drops
            end
            if (do_write) begin
                aw_ff     <= 1'b0;
                w_ff      <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? `RS_RESP_OKAY : `RS_RESP_SLVERR;
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic        trig_ext_ff, line_mode_ff;
    logic [9:0]  count_ff;
    logic [15:0] aper_ff;
    logic [7:0]  lcc_ff;
    logic [7:0]  res_lcc;
    logic [9:0]  count_clamped;

    // Resolution code to line-cycle count; finer resolution integrates longer
    assign res_lcc = (wdata_ff[1:0] == 2'h0) ? `RS_RES_LCC0 :
                     (wdata_ff[1:0] == 2'h1) ? `RS_RES_LCC1 : `RS_RES_LCC2;
    // Counts above capacity clamp, zero becomes one reading
    assign count_clamped = (wdata_ff[31:9] != 23'h0) ? `RS_MEM_DEPTH :
                           (wdata_ff[8:0] == 9'h0) ? `RS_COUNT_RST : {1'b0, wdata_ff[8:0]};

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            {line_mode_ff, trig_ext_ff} <= `RS_CFG_RST;
            count_ff <= `RS_COUNT_RST;
            aper_ff  <= `RS_APER_RST;
            lcc_ff   <= `RS_LCC_RST;
        end else begin
            if (wr_cfg) begin
                trig_ext_ff  <= wdata_ff[`RS_CFG_EXT];
                line_mode_ff <= wdata_ff[`RS_CFG_LINE];
            end
            if (wr_count) begin
                count_ff <= count_clamped;
            end
            if (wr_aper) begin
                aper_ff <= wdata_ff[15:0];
            end
            if (wr_lcc) begin
                lcc_ff <= wdata_ff[7:0];
            end else if (wr_res) begin
                lcc_ff       <= res_lcc;
                line_mode_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // Acquisition sequencer
    // ****************************************
    rs_pkg::state_t state_ff, nxt_state;
    logic        stored_ff, trig_prev_ff;
    logic [9:0]  taken_ff, stored_cnt_ff, rd_idx_ff;
    logic [31:0] cnt_ff, acc_ff, reading_ff;
    logic [31:0] mem [0:511];
    logic        fifo_in_ready, fifo_out_valid;
    logic [31:0] fifo_out_data;
    logic [5:0]  fifo_level;

    wire        idle       = state_ff == rs_pkg::S_IDLE;
    wire        req_init   = wr_ctrl && wdata_ff[`RS_CTRL_INIT] && idle;
    wire        req_read   = wr_ctrl && wdata_ff[`RS_CTRL_READ] && idle && !req_init;
    wire        req_fetch  = wr_ctrl && wdata_ff[`RS_CTRL_FETCH] && idle
                             && !req_init && !req_read && stored_cnt_ff != 10'h0;
    wire        trig_edge  = EXT_TRIG && !trig_prev_ff;
    wire        last       = taken_ff == count_ff - 10'h1;
    wire [39:0] line_len   = 40'(lcc_ff) * 40'(LINE_CLKS);
    wire [31:0] integ_len  = line_mode_ff ? line_len[31:0] : 32'(aper_ff);
    wire        integ_done = cnt_ff + 32'h1 >= integ_len;
    wire        fifo_push  = (state_ff == rs_pkg::S_PUSH) || (state_ff == rs_pkg::S_FETCH);
    wire [31:0] fifo_in    = (state_ff == rs_pkg::S_FETCH) ? mem[rd_idx_ff[8:0]] : reading_ff;
    wire        fetch_last = rd_idx_ff == stored_cnt_ff - 10'h1;
    wire        pop        = do_read && S_AXI_ARADDR == `RS_ADDR_DATA && fifo_out_valid;

    // Next state; triggers outside the wait state fall through unseen
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rs_pkg::S_IDLE: begin
                if (req_init || req_read) begin
                    nxt_state = trig_ext_ff ? rs_pkg::S_WAIT_TRIG : rs_pkg::S_INTEG;
                end else if (req_fetch) begin
                    nxt_state = rs_pkg::S_FETCH;
                end
            end
            rs_pkg::S_WAIT_TRIG: begin
                if (trig_edge) begin
                    nxt_state = rs_pkg::S_INTEG;
                end
            end
            rs_pkg::S_INTEG: begin
                if (integ_done) begin
                    nxt_state = stored_ff ? rs_pkg::S_STORE : rs_pkg::S_PUSH;
                end
            end
            rs_pkg::S_STORE: begin
                nxt_state = last ? rs_pkg::S_IDLE : rs_pkg::S_INTEG;
            end
            rs_pkg::S_PUSH: begin
                if (fifo_in_ready) begin
                    nxt_state = last ? rs_pkg::S_IDLE : rs_pkg::S_INTEG;
                end
            end
            rs_pkg::S_FETCH: begin
                if (fifo_in_ready && fetch_last) begin
                    nxt_state = rs_pkg::S_IDLE;
                end
            end
            default: nxt_state = rs_pkg::S_IDLE;
        endcase
    end

    // Sequencer state, mode and counters
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_ff      <= rs_pkg::S_IDLE;
            stored_ff     <= 1'b0;
            trig_prev_ff  <= 1'b0;
            taken_ff      <= 10'h0;
            stored_cnt_ff <= 10'h0;
            rd_idx_ff     <= 10'h0;
        end else begin
            state_ff     <= nxt_state;
            trig_prev_ff <= EXT_TRIG;
            if (req_init || req_read) begin
                stored_ff <= req_init;
                taken_ff  <= 10'h0;
            end
            if (req_init) begin
                stored_cnt_ff <= 10'h0;
            end
            if (state_ff == rs_pkg::S_STORE) begin
                taken_ff      <= taken_ff + 10'h1;
                stored_cnt_ff <= taken_ff + 10'h1;
            end
            if (state_ff == rs_pkg::S_PUSH && fifo_in_ready) begin
                taken_ff <= taken_ff + 10'h1;
            end
            if (req_fetch) begin
                rd_idx_ff <= 10'h0;
            end else if (state_ff == rs_pkg::S_FETCH && fifo_in_ready) begin
                rd_idx_ff <= rd_idx_ff + 10'h1;
            end
        end
    end

    // Integrator sums the input over the chosen window
    always_ff @(posedge CLOCK) begin
        if (RESET || state_ff != rs_pkg::S_INTEG) begin
            cnt_ff <= 32'h0;
            acc_ff <= 32'h0;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
            acc_ff <= acc_ff + 32'(SENSE_IN);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            reading_ff <= 32'h0;
        end else if (state_ff == rs_pkg::S_INTEG && integ_done) begin
            reading_ff <= acc_ff + 32'(SENSE_IN);
        end
    end

    // Reading memory; index bounded by the clamped count
    always_ff @(posedge CLOCK) begin
        if (state_ff == rs_pkg::S_STORE) begin
            mem[taken_ff[8:0]] <= reading_ff;
        end
    end

    // ****************************************
    // Output buffer and register reads
    // ****************************************
    // Stored readings reach the buffer only from the fetch state
    reading_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_out_buf (
        .clk       (CLOCK),
        .rst       (RESET),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    wire [31:0] status = {10'h0, fifo_level, 2'h0, stored_cnt_ff, fifo_out_valid, state_ff};
    wire [31:0] rd_mux =
        (S_AXI_ARADDR == `RS_ADDR_CONFIG) ? {30'h0, line_mode_ff, trig_ext_ff} :
        (S_AXI_ARADDR == `RS_ADDR_COUNT)  ? {22'h0, count_ff} :
        (S_AXI_ARADDR == `RS_ADDR_APER)   ? {16'h0, aper_ff} :
        (S_AXI_ARADDR == `RS_ADDR_LCC)    ? {24'h0, lcc_ff} :
        (S_AXI_ARADDR == `RS_ADDR_STATUS) ? status :
        (S_AXI_ARADDR == `RS_ADDR_DATA && fifo_out_valid) ? fifo_out_data : 32'h0;

    // Read data registered; a data read pops one reading
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0;
            rresp_ff  <= `RS_RESP_OKAY;
        end else if (do_read) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_hit ? `RS_RESP_OKAY : `RS_RESP_SLVERR;
        end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    AST_MEM_BOUND: assert property (state_ff == rs_pkg::S_STORE |->
        taken_ff < `RS_MEM_DEPTH) else $error("store index beyond memory");
    AST_BURST_LEN: assert property (state_ff == rs_pkg::S_STORE && last |=>
        stored_cnt_ff == count_ff) else $error("stored count differs from sample count");
    AST_IMM_START: assert property ((req_init || req_read) && !trig_ext_ff |=>
        state_ff == rs_pkg::S_INTEG) else $error("immediate trigger did not start");
    AST_EXT_HOLD: assert property (state_ff == rs_pkg::S_WAIT_TRIG && !trig_edge |=>
        state_ff == rs_pkg::S_WAIT_TRIG) else $error("acquisition began without trigger");
    AST_FETCH_COPY: assert property (state_ff == rs_pkg::S_FETCH |->
        rd_idx_ff < stored_cnt_ff) else $error("fetch read beyond stored readings");
    AST_NO_EARLY: assert property (fifo_push && stored_ff |->
        state_ff == rs_pkg::S_FETCH) else $error("stored reading output before fetch");
    AST_BYPASS: assert property (state_ff == rs_pkg::S_STORE |->
        stored_ff) else $error("direct mode wrote reading memory");
    AST_DIRECT_PUSH: assert property (state_ff == rs_pkg::S_INTEG && integ_done &&
        !stored_ff |=> fifo_push && fifo_in == $past(acc_ff) + 32'($past(SENSE_IN)))
        else $error("direct reading not offered");
    AST_PAUSE: assert property (state_ff == rs_pkg::S_PUSH && !fifo_in_ready |=>
        state_ff == rs_pkg::S_PUSH && $stable(taken_ff)) else $error("no pause on full buffer");
    AST_INTEG_LEN: assert property (state_ff == rs_pkg::S_INTEG && !integ_done |=>
        $stable(state_ff) && cnt_ff == $past(cnt_ff) + 32'h1) else $error("window cut short");
    AST_RES_MAP: assert property (wr_res && !wr_lcc |=>
        lcc_ff == $past(res_lcc) && line_mode_ff) else $error("resolution not applied");
    AST_EARLY_TRIG: assert property (idle && trig_edge && !req_init && !req_read |=>
        state_ff != rs_pkg::S_INTEG) else $error("early trigger started acquisition");
    AST_COUNT_CAP: assert property (count_ff <= `RS_MEM_DEPTH && count_ff != 10'h0)
        else $error("sample count outside capacity");

    COV_STORED: cover property (state_ff == rs_pkg::S_STORE && last);
    COV_FETCH: cover property (state_ff == rs_pkg::S_FETCH ##1 state_ff == rs_pkg::S_IDLE);
    COV_PAUSE: cover property (state_ff == rs_pkg::S_PUSH && !fifo_in_ready);
    COV_EXT: cover property (state_ff == rs_pkg::S_WAIT_TRIG ##1 state_ff == rs_pkg::S_INTEG);
endmodule : reading_store

// ---- pkg/rs_defs.svh ----
// Offsets, field positions, reset values and timing periods of the reading store
`ifndef RS_DEFS_SVH
`define RS_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define RS_ADDR_CTRL     8'h00
`define RS_ADDR_CONFIG   8'h04
`define RS_ADDR_COUNT    8'h08
`define RS_ADDR_APER     8'h0c
`define RS_ADDR_LCC      8'h10
`define RS_ADDR_RES      8'h14
`define RS_ADDR_STATUS   8'h18
`define RS_ADDR_DATA     8'h1c

// ****************************************
// Field positions
// ****************************************
`define RS_CTRL_INIT     0
`define RS_CTRL_FETCH    1
`define RS_CTRL_READ     2
`define RS_CFG_EXT       0
`define RS_CFG_LINE      1

// ****************************************
// Reset values, limits, resolution line counts and response codes
// ****************************************
`define RS_MEM_DEPTH     10'h200
`define RS_COUNT_RST     10'h001
`define RS_APER_RST      16'h0064
`define RS_LCC_RST       8'h0a
`define RS_CFG_RST       2'h2
`define RS_RES_LCC0      8'h64
`define RS_RES_LCC1      8'h0a
`define RS_RES_LCC2      8'h01
`define RS_RESP_OKAY     2'h0
`define RS_RESP_SLVERR   2'h2

// ****************************************
// Timing
// ****************************************
`define RS_CLK_PERIOD_NS 100
`define RS_LINE_PERIOD_NS 20000000

`endif

// ---- pkg/rs_pkg.sv ----
// Types shared by the reading store design
package rs_pkg;
    typedef enum logic [2:0] {
        S_IDLE,
        S_WAIT_TRIG,
        S_INTEG,
        S_STORE,
        S_PUSH,
        S_FETCH
    } state_t;
endpackage : rs_pkg

// ---- verification/host_model.sv ----
// Host controller model: AXI4-Lite master that programs and drains the block
`timescale 1ns/1ns
module host_model (
    // Clock
    input  wire logic        CLOCK,
    // Write channels
    output logic [7:0]       S_AXI_AWADDR,
    output logic             S_AXI_AWVALID,
    input  wire logic        S_AXI_AWREADY,
    output logic [31:0]      S_AXI_WDATA,
    output logic [3:0]       S_AXI_WSTRB,
    output logic             S_AXI_WVALID,
    input  wire logic        S_AXI_WREADY,
    input  wire logic [1:0]  S_AXI_BRESP,
    input  wire logic        S_AXI_BVALID,
    output logic             S_AXI_BREADY,
    // Read channels
    output logic [7:0]       S_AXI_ARADDR,
    output logic             S_AXI_ARVALID,
    input  wire logic        S_AXI_ARREADY,
    input  wire logic [31:0] S_AXI_RDATA,
    input  wire logic [1:0]  S_AXI_RRESP,
    input  wire logic        S_AXI_RVALID,
    output logic             S_AXI_RREADY
);
    // ********
    // Bus master
    // ********
    // Idle bus from time zero
    initial begin
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = 52'h0;
    end
    // Released payload is inverted so a stale value never passes for a live one
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge CLOCK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= 4'hf;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        fork
            begin
                do @(posedge CLOCK); while (!S_AXI_AWREADY);
                S_AXI_AWVALID <= 1'b0;
                S_AXI_AWADDR <= ~a;
            end
            begin
                do @(posedge CLOCK); while (!S_AXI_WREADY);
                S_AXI_WVALID <= 1'b0;
                S_AXI_WDATA <= ~d;
            end
            begin
                do @(posedge CLOCK); while (!S_AXI_BVALID);
                S_AXI_BREADY <= 1'b0;
                r = S_AXI_BRESP;
            end
        join
    endtask : wr
    // Drain pace is set by the caller, so the reading rate may vary
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLOCK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do @(posedge CLOCK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        S_AXI_ARADDR <= ~a;
        do @(posedge CLOCK); while (!S_AXI_RVALID);
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask : rd
endmodule : host_model

// ---- verification/reading_store_tb_top.sv ----
// Self-checking bench for the reading store and its host
`timescale 1ns/1ns
`include "rs_defs.svh"
module reading_store_tb_top;
    logic        clk, rst, trig;
    logic [15:0] sense, v, lf;
    logic [31:0] rdat, S_AXI_WDATA, S_AXI_RDATA;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  resp, S_AXI_BRESP, S_AXI_RRESP;
    logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    int          n_mismatch, checked, n, k;
    // Short line period keeps line-cycle windows at four clocks
    reading_store #(.LINE_CLKS(4), .FIFO_DEPTH(32)) reading_store_i (
        .CLOCK(clk), .RESET(rst), .SENSE_IN(sense), .EXT_TRIG(trig),
        .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
        .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
        .S_AXI_RVALID, .S_AXI_RREADY);
    host_model host_model_i (
        .CLOCK(clk),
        .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
        .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
        .S_AXI_RVALID, .S_AXI_RREADY);
    // ********
    // Helpers
    // ********
    initial clk = 1'b0;
    always #50 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // A reading is the plain sum over its window
    function automatic logic [31:0] reading(input logic [15:0] s, input logic [31:0] w);
        return {16'h0000, s} * w;
    endfunction : reading
    function automatic logic [31:0] res_lcc(input logic [1:0] c);
        return (c == 2'h0) ? 32'h64 : ((c == 2'h1) ? 32'h0a : 32'h01);
    endfunction : res_lcc
    // Unmapped or unaligned is an error; status and data also refuse writes
    function automatic logic [31:0] exp_resp(input logic [7:0] a, input logic w);
        if (a > `RS_ADDR_DATA || a[1:0] != 2'h0
            || (w && (a == `RS_ADDR_STATUS || a == `RS_ADDR_DATA))) begin
            return 32'(`RS_RESP_SLVERR);
        end
        return 32'(`RS_RESP_OKAY);
    endfunction : exp_resp
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_model_i.wr(a, d, resp);
        chk("bresp", exp_resp(a, 1'b1), 32'(resp));
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
        host_model_i.rd(a, rdat, resp);
        chk(what, e, rdat);
        chk("rresp", exp_resp(a, 1'b0), 32'(resp));
    endtask : rdchk
    // Poll status under a bound; a miss is reported with the last value
    task automatic wait_status(input logic [31:0] m, input logic [31:0] e);
        int i;
        for (i = 0; i < 400; i++) begin
            host_model_i.rd(`RS_ADDR_STATUS, rdat, resp);
            if ((rdat & m) === e) break;
        end
        chk("status", e, rdat & m);
    endtask : wait_status
    task automatic new_value;
        v = lf;
        lf = lfsr(lf);
        @(posedge clk);
        sense <= v;
    endtask : new_value
    task automatic pulse_trig;
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
    endtask : pulse_trig
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    // Watchdog of 50000 cycles, far beyond the roughly six hundred cycles the run needs
    initial begin
        #5000000;
        n_mismatch++;
        final_report();
    end
    // ********
    // Scenarios
    // ********
    initial begin
        rst = 1'b1;
        trig = 1'b0;
        sense = 16'h0000;
        lf = 16'hea66;
        n_mismatch = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdchk("aperture", `RS_ADDR_APER, 32'h64);
        rdchk("lcc", `RS_ADDR_LCC, 32'h0a);
        rdchk("unmapped", 8'h20, 32'h0);
        wr(`RS_ADDR_STATUS, 32'hffff_ffff);
        rdchk("status ro", `RS_ADDR_STATUS, 32'h0);
        wr(`RS_ADDR_COUNT, 32'h258);
        rdchk("count clamp", `RS_ADDR_COUNT, 32'h200);
        wr(`RS_ADDR_COUNT, 32'h0);
        rdchk("count zero", `RS_ADDR_COUNT, 32'h1);
        // Resolution codes 0 to 2, each forcing line mode back on
        for (k = 0; k < 3; k++) begin
            wr(`RS_ADDR_CONFIG, 32'h0);
            wr(`RS_ADDR_RES, 32'(k));
            rdchk("res lcc", `RS_ADDR_LCC, res_lcc(k[1:0]));
            rdchk("res mode", `RS_ADDR_CONFIG, 32'h2);
        end
        // One line-cycle reading, direct
        new_value();
        wr(`RS_ADDR_CTRL, 32'h4);
        wait_status(32'h0f, 32'h08);
        rdchk("line data", `RS_ADDR_DATA, reading(v, 32'h4));
        // Stored burst, immediate trigger, then fetch
        n = 2 + int'(lf[1:0]);
        new_value();
        wr(`RS_ADDR_APER, 32'h3);
        wr(`RS_ADDR_CONFIG, 32'h0);
        wr(`RS_ADDR_COUNT, 32'(n));
        wr(`RS_ADDR_CTRL, 32'h1);
        wait_status(32'h3fff, 32'(n) << 4);
        wr(`RS_ADDR_CTRL, 32'h2);
        wait_status(32'h0f, 32'h08);
        for (k = 0; k < n; k++) begin
            rdchk("fetched", `RS_ADDR_DATA, reading(v, 32'h3));
        end
        rdchk("empty", `RS_ADDR_DATA, 32'h0);
        // Direct burst on external trigger; the early edge must be lost
        new_value();
        wr(`RS_ADDR_CONFIG, 32'h1);
        pulse_trig();
        wr(`RS_ADDR_CTRL, 32'h4);
        repeat (20) @(posedge clk);
        wait_status(32'h3ff7, (32'(n) << 4) | 32'h1);
        pulse_trig();
        wait_status(32'h3fff, (32'(n) << 4) | 32'h8);
        for (k = 0; k < n; k++) begin
            rdchk("direct", `RS_ADDR_DATA, reading(v, 32'h3));
        end
        // Slow host: a burst larger than the buffer must stall, not drop
        new_value();
        wr(`RS_ADDR_CONFIG, 32'h0);
        wr(`RS_ADDR_COUNT, 32'h28);
        wr(`RS_ADDR_CTRL, 32'h4);
        wait_status(32'h3f000f, 32'h0020000c);
        for (k = 0; k < 40; k++) begin
            repeat (3) @(posedge clk);
            rdchk("flow data", `RS_ADDR_DATA, reading(v, 32'h3));
        end
        wait_status(32'h3f000f, 32'h0);
        final_report();
    end
endmodule : reading_store_tb_top
